// [src/wts_channel.sv]
// One channel of the weekly time switch: event and window decode
`timescale 1ns/10ps
`default_nettype none
`include "wts_map.svh"

module wts_channel
  import wts_pkg::*;
(
  input  wire logic [31:0] cfgWord,    // Sanitised channel word
  input  wire logic [2:0]  nowWeekday, // 0 Sunday .. 6 Saturday
  input  wire logic [4:0]  nowHour,    // 0 .. 23
  input  wire logic [5:0]  nowMinute,  // 0 .. 59
  output logic             onHit,      // On point matches this minute
  output logic             offHit,     // Off point matches this minute
  output logic             inWindow    // Current time inside on period
);

  wts_chan_t  cfg;
  wts_mins_t  onTime;
  wts_mins_t  offTime;
  wts_mins_t  nowTime;
  logic [2:0] yesterday;
  logic       dayToday;
  logic       dayYesterday;
  logic       overnight;
  logic       sameTime;

  // Day range test, wrapping across the week end
  function automatic logic wts_day_ok(input wts_chan_t c, input logic [2:0] d);
    logic ok;
    ok = 1'b0;
    if (c.firstSet && c.secondSet) begin
      if (c.firstWeekday <= c.secondWeekday) begin
        ok = (d >= c.firstWeekday) && (d <= c.secondWeekday);
      end else begin
        ok = (d >= c.firstWeekday) || (d <= c.secondWeekday);
      end
    end else if (c.firstSet) begin
      ok = (d == c.firstWeekday);
    end else if (c.secondSet) begin
      ok = (d == c.secondWeekday);
    end
    return ok;
  endfunction : wts_day_ok

  // Time conversion and day lookups
  assign cfg          = wts_chan_t'(cfgWord);
  assign onTime       = wts_mins_t'(cfg.onHour * `WTS_MIN_PER_HOUR) + wts_mins_t'(cfg.onMinute);
  assign offTime      = wts_mins_t'(cfg.offHour * `WTS_MIN_PER_HOUR) + wts_mins_t'(cfg.offMinute);
  assign nowTime      = wts_mins_t'(nowHour * `WTS_MIN_PER_HOUR) + wts_mins_t'(nowMinute);
  assign yesterday    = (nowWeekday == `WTS_DAY_SUNDAY) ? `WTS_DAY_SATURDAY : nowWeekday - 3'h1;
  assign dayToday     = wts_day_ok(cfg, nowWeekday);
  assign dayYesterday = wts_day_ok(cfg, yesterday);
  assign sameTime     = cfg.offSet && (offTime == onTime);
  assign overnight    = cfg.offSet && cfg.onSet && (offTime < onTime);

  // Events; an unset point never fires
  assign onHit  = cfg.onSet && dayToday && (nowTime == onTime) && !sameTime;
  assign offHit = cfg.offSet && (overnight ? dayYesterday : dayToday)
                  && (nowTime == offTime);

  // Level used when the state is recomputed
  always_comb begin
    inWindow = 1'b0;
    if (!cfg.onSet || sameTime) begin
      inWindow = 1'b0;
    end else if (!cfg.offSet) begin
      inWindow = dayToday && (nowTime >= onTime);
    end else if (overnight) begin
      inWindow = (dayToday && (nowTime >= onTime))
                 || (dayYesterday && (nowTime < offTime));
    end else begin
      inWindow = dayToday && (nowTime >= onTime) && (nowTime < offTime);
    end
  end

endmodule : wts_channel
`default_nettype wire

// [src/wts_map.svh]
// Register offsets, field positions and reset values of the weekly time switch
`ifndef WTS_MAP_SVH
`define WTS_MAP_SVH

// Byte offsets on the register bus
`define WTS_OFS_CTRL      5'h00
`define WTS_OFS_STATUS    5'h04
`define WTS_OFS_CH_BASE   5'h10
`define WTS_ADDR_W        5

// Control register fields
`define WTS_CTRL_EN_GATE  0
`define WTS_CTRL_EDIT_OK  1
`define WTS_CTRL_RUN_MODE 2
`define WTS_CTRL_RESET    3'h0

// Status register fields
`define WTS_STAT_SWITCH   0
`define WTS_STAT_POWER    1
`define WTS_STAT_ACTIVE   2

// Channel word fields
`define WTS_CH_FDAY_LSB   0
`define WTS_CH_FSET       3
`define WTS_CH_SDAY_LSB   4
`define WTS_CH_SSET       7
`define WTS_CH_ONH_LSB    8
`define WTS_CH_ONM_LSB    13
`define WTS_CH_ONSET      19
`define WTS_CH_OFFH_LSB   20
`define WTS_CH_OFFM_LSB   25
`define WTS_CH_OFFSET     31
`define WTS_CH_RESET      32'h0000_0000

// Time arithmetic
`define WTS_MIN_PER_HOUR  11'h03C
`define WTS_DAY_SUNDAY    3'h0
`define WTS_DAY_SATURDAY  3'h6

`endif

// [src/wts_pkg.sv]
// Types shared by the weekly time switch modules
package wts_pkg;

  // One channel: two weekdays, on point and off point
  typedef struct packed {
    logic       offSet;
    logic [5:0] offMinute;
    logic [4:0] offHour;
    logic       onSet;
    logic [5:0] onMinute;
    logic [4:0] onHour;
    logic       secondSet;
    logic [2:0] secondWeekday;
    logic       firstSet;
    logic [2:0] firstWeekday;
  } wts_chan_t;

  // Minutes since midnight
  typedef logic [10:0] wts_mins_t;

endpackage : wts_pkg

// [src/wts_top.sv]
// Weekly time switch: four channels, one switch output, Avalon-MM registers
`timescale 1ns/10ps
`default_nettype none
`include "wts_map.svh"

module wts_top
  import wts_pkg::*;
#(
  parameter int NUM_CHANNELS = 4 // Channels A to D
) (
  input  wire logic        core_clk,          // 40 MHz clock
  input  wire logic        srst,              // Synchronous reset, high
  input  wire logic [4:0]  avs_address,       // Byte address
  input  wire logic        avs_read,          // Read request
  input  wire logic        avs_write,         // Write request
  input  wire logic [31:0] avs_writedata,     // Write data
  input  wire logic [3:0]  avs_byteenable,    // Byte lanes
  output logic      [31:0] avs_readdata,      // Read data
  output logic             avs_waitrequest,   // Stall
  input  wire logic [2:0]  rtcWeekday,        // Clock weekday, 0 Sunday
  input  wire logic [4:0]  rtcHour,           // Clock hour
  input  wire logic [5:0]  rtcMinute,         // Clock minute
  input  wire logic        blockEnable,       // Block enable input
  input  wire logic        supplyGood,        // Supply present, pin
  output logic             switchOutput       // Switch output
);

  logic [31:0]             chanCfg [NUM_CHANNELS];
  logic [2:0]              ctrl;
  logic                    pgS1;
  logic                    pgS2;
  logic                    pgS3;
  logic                    pgState;
  logic                    pgPrev;
  logic                    activePrev;
  logic                    needEval;
  logic [5:0]              lastMinute;
  logic [NUM_CHANNELS-1:0] onHits;
  logic [NUM_CHANNELS-1:0] offHits;
  logic [NUM_CHANNELS-1:0] windows;
  logic                    anyOn;
  logic                    anyOff;
  logic                    anyWindow;
  logic                    active;
  logic                    minuteTick;
  logic                    busReq;
  logic                    busDone;
  logic                    wrCtrl;
  logic                    wrChan;
  logic                    chanEditOk;
  logic [1:0]              chanIdx;
  logic [31:0]             laneMask;
  logic [31:0]             next_chan;

  // Channel word clean-up: keeps day and time consistent
  function automatic logic [31:0] wts_fix(input logic [31:0] oldW, input logic [31:0] newW);
    wts_chan_t o;
    wts_chan_t n;
    o = wts_chan_t'(oldW);
    n = wts_chan_t'(newW);
    if (o.firstSet && !n.firstSet) begin
      n.onSet    = 1'b0;
      n.onHour   = 5'h00;
      n.onMinute = 6'h00;
    end else if (n.onSet && !n.firstSet) begin
      n.firstSet     = 1'b1;
      n.firstWeekday = `WTS_DAY_SUNDAY;
    end
    if (o.secondSet && !n.secondSet) begin
      n.offSet    = 1'b0;
      n.offHour   = 5'h00;
      n.offMinute = 6'h00;
    end else if (n.offSet && !n.secondSet) begin
      n.secondSet     = 1'b1;
      n.secondWeekday = `WTS_DAY_SUNDAY;
    end
    if (n.secondSet && !n.firstSet) begin
      n.firstSet     = 1'b1;
      n.firstWeekday = `WTS_DAY_SUNDAY;
      n.onSet        = 1'b1;
      n.onHour       = 5'h00;
      n.onMinute     = 6'h00;
    end
    if (n.firstSet && !n.onSet) begin
      n.onSet    = 1'b1;
      n.onHour   = 5'h00;
      n.onMinute = 6'h00;
    end
    if (n.secondSet && !n.offSet) begin
      n.offSet    = 1'b1;
      n.offHour   = 5'h00;
      n.offMinute = 6'h00;
    end
    return 32'(n);
  endfunction : wts_fix

  // One decoder per channel
  for (genvar g = 0; g < NUM_CHANNELS; g++) begin : gChan
    wts_channel uChan (
      .cfgWord    (chanCfg[g]),
      .nowWeekday (rtcWeekday),
      .nowHour    (rtcHour),
      .nowMinute  (rtcMinute),
      .onHit      (onHits[g]),
      .offHit     (offHits[g]),
      .inWindow   (windows[g])
    );
  end

  // Channel results merged onto one output
  assign anyOn     = |onHits;
  assign anyOff    = |offHits;
  assign anyWindow = |windows;
  assign active    = !ctrl[`WTS_CTRL_EN_GATE] || blockEnable;
  assign minuteTick = (rtcMinute != lastMinute);

  // Bus decode
  assign busReq     = avs_read || avs_write;
  assign busDone    = busReq && !avs_waitrequest;
  assign wrCtrl     = busDone && avs_write && (avs_address == `WTS_OFS_CTRL);
  assign wrChan     = busDone && avs_write && (avs_address[4] == 1'b1);
  assign chanIdx    = avs_address[3:2];
  assign chanEditOk = !ctrl[`WTS_CTRL_RUN_MODE] || ctrl[`WTS_CTRL_EDIT_OK];
  assign laneMask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign next_chan  = wts_fix(chanCfg[chanIdx],
                              (chanCfg[chanIdx] & ~laneMask) | (avs_writedata & laneMask));

  // Supply pin synchroniser, change taken when stages two and three agree
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pgS1    <= 1'b0;
      pgS2    <= 1'b0;
      pgS3    <= 1'b0;
      pgState <= 1'b0;
    end else begin
      pgS1 <= supplyGood;
      pgS2 <= pgS1;
      pgS3 <= pgS2;
      if (pgS2 == pgS3) begin
        pgState <= pgS3;
      end
    end
  end

  // Wait state: one stall cycle per request
  always_ff @(posedge core_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(busReq && avs_waitrequest);
    end
  end

  // Read data, captured in the stall cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= 32'h0000_0000;
      if (avs_address == `WTS_OFS_CTRL) begin
        avs_readdata <= {29'h0000_0000, ctrl};
      end else if (avs_address == `WTS_OFS_STATUS) begin
        avs_readdata <= {29'h0000_0000, active, pgState, switchOutput};
      end else if (avs_address[4]) begin
        avs_readdata <= chanCfg[chanIdx];
      end
    end
  end

  // Control register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl <= `WTS_CTRL_RESET;
    end else if (wrCtrl && avs_byteenable[0]) begin
      ctrl <= avs_writedata[2:0];
    end
  end

  // Channel words; nothing survives a reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        chanCfg[i] <= `WTS_CH_RESET;
      end
    end else if (wrChan && chanEditOk) begin
      chanCfg[chanIdx] <= next_chan;
    end
  end

  // Edge history of supply, enable and minute
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pgPrev     <= 1'b0;
      activePrev <= 1'b0;
      lastMinute <= 6'h00;
    end else begin
      pgPrev     <= pgState;
      activePrev <= active;
      lastMinute <= rtcMinute;
    end
  end

  // Recompute request after reset, power-up, enable or new settings
  always_ff @(posedge core_clk) begin
    if (srst) begin
      needEval <= 1'b1;
    end else if ((pgState && !pgPrev) || (active && !activePrev) || wrChan) begin
      needEval <= 1'b1;
    end else if (pgState && active) begin
      needEval <= 1'b0;
    end
  end

  // Switch output state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      switchOutput <= 1'b0;
    end else if (!pgState || !active) begin
      switchOutput <= 1'b0;
    end else if (needEval) begin
      switchOutput <= anyWindow;
    end else if (minuteTick && anyOff) begin
      switchOutput <= 1'b0;
    end else if (minuteTick && anyOn) begin
      switchOutput <= 1'b1;
    end
  end

  // Checks
  function automatic logic wts_orphan_time(input logic [31:0] w);
    return (w[`WTS_CH_ONSET] && !w[`WTS_CH_FSET]) || (w[`WTS_CH_OFFSET] && !w[`WTS_CH_SSET]);
  endfunction : wts_orphan_time

  sequence runningS;
    pgState && active && !needEval;
  endsequence

  sequence busReqS;
    busReq && avs_waitrequest;
  endsequence

  sequence powerUpS;
    pgState && !pgPrev && active;
  endsequence

  sequence chanWrS;
    wrChan && chanEditOk;
  endsequence

  // Supply loss and gating force the switch low, a clear gate bit ignores the enable, the synchroniser takes the supply level
  power_loss_a: assert property (@(posedge core_clk) disable iff (srst)
    !pgState |=> !switchOutput)
    else $error("switch high while supply lost");

  gate_off_a: assert property (@(posedge core_clk) disable iff (srst)
    ctrl[`WTS_CTRL_EN_GATE] && !blockEnable |=> !switchOutput)
    else $error("switch high while gated off");

  gate_ignored_a: assert property (@(posedge core_clk) disable iff (srst)
    !ctrl[`WTS_CTRL_EN_GATE] && pgState && !needEval && minuteTick && anyOn && !anyOff
    |=> switchOutput)
    else $error("enable input not ignored");

  supply_sync_a: assert property (@(posedge core_clk) disable iff (srst)
    pgS2 && pgS3 |=> pgState)
    else $error("supply level not taken");

  // Events taken at the minute tick
  off_event_a: assert property (@(posedge core_clk) disable iff (srst)
    runningS ##0 (minuteTick && anyOff) |=> !switchOutput)
    else $error("off event did not clear switch");

  on_event_a: assert property (@(posedge core_clk) disable iff (srst)
    runningS ##0 (minuteTick && anyOn && !anyOff) |=> switchOutput)
    else $error("on event did not set switch");

  off_wins_a: assert property (@(posedge core_clk) disable iff (srst)
    runningS ##0 (minuteTick && anyOn && anyOff) |=> !switchOutput)
    else $error("on event beat an off event");

  hold_quiet_a: assert property (@(posedge core_clk) disable iff (srst)
    runningS ##0 (!minuteTick && !wrChan) ##1 (pgState && active)
    |-> $stable(switchOutput))
    else $error("switch changed without an event");

  // Recompute of the state from all channels
  power_up_a: assert property (@(posedge core_clk) disable iff (srst)
    powerUpS |=> needEval ##1 (switchOutput == $past(anyWindow)))
    else $error("state not recomputed at power-up");

  write_eval_a: assert property (@(posedge core_clk) disable iff (srst)
    wrChan |=> needEval)
    else $error("channel write did not request recompute");

  eval_load_a: assert property (@(posedge core_clk) disable iff (srst)
    pgState && active && needEval |=> (switchOutput == $past(anyWindow)))
    else $error("recompute did not load window state");

  // Bus handshake and read data
  bus_answer_a: assert property (@(posedge core_clk) disable iff (srst)
    busReqS |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one stall cycle");

  stall_idle_a: assert property (@(posedge core_clk) disable iff (srst)
    !busReq |=> avs_waitrequest)
    else $error("waitrequest low without a request");

  idle_read_a: assert property (@(posedge core_clk) disable iff (srst)
    !avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");

  read_ctrl_a: assert property (@(posedge core_clk) disable iff (srst)
    busReqS ##0 (avs_read && (avs_address == `WTS_OFS_CTRL))
    |=> (avs_readdata == {29'h0, $past(ctrl)}))
    else $error("control read data wrong");

  // Stored channel words
  day_time_a: assert property (@(posedge core_clk) disable iff (srst)
    !wts_orphan_time(chanCfg[0]) && !wts_orphan_time(chanCfg[1])
    && !wts_orphan_time(chanCfg[2]) && !wts_orphan_time(chanCfg[3]))
    else $error("time stored without a weekday");

  edit_lock_a: assert property (@(posedge core_clk) disable iff (srst)
    wrChan && !chanEditOk |=> $stable(chanCfg[0]) && $stable(chanCfg[1])
    && $stable(chanCfg[2]) && $stable(chanCfg[3]))
    else $error("channel changed while editing locked");

  edit_write_a: assert property (@(posedge core_clk) disable iff (srst)
    chanWrS ##0 (chanIdx == 2'h0) |=> (chanCfg[0] == $past(next_chan)))
    else $error("allowed channel write not stored");

endmodule : wts_top
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench of the weekly time switch against a behavioural model
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import wts_pkg::*;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [3:0]  beMask = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  rtcWeekday;
  logic [4:0]  rtcHour;
  logic [5:0]  rtcMinute;
  logic        blockEnable = 1'b1;
  logic        supplyGood = 1'b1;
  logic        switchOutput;
  logic        load = 1'b1;
  logic        step = 1'b0;
  logic [2:0]  setDay = 3'h0;
  logic [4:0]  setHour = 5'h00;
  logic [5:0]  setMinute = 6'h00;
  logic [31:0] q;
  int          failures = 0;
  int          tests_run = 0;
  int          fd[4], sd[4], onM[4], offM[4];
  int          curD = 0, curM = 0;
  bit          expOut = 1'b0, run = 1'b1;

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  wts_top DUT (.core_clk(core_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .rtcWeekday(rtcWeekday), .rtcHour(rtcHour), .rtcMinute(rtcMinute),
    .blockEnable(blockEnable), .supplyGood(supplyGood), .switchOutput(switchOutput));

  wts_rtc_model RTC (.core_clk(core_clk), .load(load), .setDay(setDay), .setHour(setHour),
    .setMinute(setMinute), .step(step), .rtcWeekday(rtcWeekday), .rtcHour(rtcHour),
    .rtcMinute(rtcMinute));

  // Model: is weekday d among the channel's days
  function automatic bit inRange(int c, int d);
    if (fd[c] < 0) return 1'b0;
    if (sd[c] < 0) return d == fd[c];
    if (fd[c] <= sd[c]) return d >= fd[c] && d <= sd[c];
    return d >= fd[c] || d <= sd[c];
  endfunction : inRange

  // Model: channel on period at day d, minute of day m
  function automatic bit win(int c, int d, int m);
    if (onM[c] < 0) return 1'b0;
    if (offM[c] < 0) return inRange(c, d) && m >= onM[c];
    if (onM[c] == offM[c]) return 1'b0;
    if (onM[c] < offM[c]) return inRange(c, d) && m >= onM[c] && m < offM[c];
    return (inRange(c, d) && m >= onM[c]) || (inRange(c, (d + 6) % 7) && m < offM[c]);
  endfunction : win

  // Model: switch events at a minute change, off before on
  task automatic evalTick();
    bit on, off;
    on = 1'b0;
    off = 1'b0;
    for (int c = 0; c < 4; c++) begin
      if (onM[c] >= 0 && onM[c] != offM[c] && inRange(c, curD) && curM == onM[c]) on = 1'b1;
      if (offM[c] >= 0 && curM == offM[c] &&
          inRange(c, (offM[c] < onM[c]) ? (curD + 6) % 7 : curD)) off = 1'b1;
    end
    if (!run) expOut = 1'b0;
    else if (off) expOut = 1'b0;
    else if (on) expOut = 1'b1;
  endtask : evalTick

  // Model: full re-evaluation from all channels
  task automatic recompute();
    expOut = 1'b0;
    for (int c = 0; c < 4; c++) expOut |= win(c, curD, curM) & run;
  endtask : recompute

  // Compare and count
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chkOut();
    repeat (4) @(posedge core_clk);
    chk({31'h0, switchOutput}, {31'h0, expOut});
  endtask : chkOut

  // One bus transfer, held until waitrequest is sampled low
  task automatic av(bit wr, logic [4:0] a, logic [31:0] d, output logic [31:0] rd);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= beMask;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av

  // Channel write with model update; -1 leaves a field unset
  task automatic wrch(int c, int f, int s, int on, int off);
    wts_chan_t w;
    logic [31:0] r;
    w = '0;
    if (f >= 0) {w.firstSet, w.firstWeekday} = {1'b1, 3'(f)};
    if (s >= 0) {w.secondSet, w.secondWeekday} = {1'b1, 3'(s)};
    if (on >= 0) {w.onSet, w.onHour, w.onMinute} = {1'b1, 5'(on / 60), 6'(on % 60)};
    if (off >= 0) {w.offSet, w.offHour, w.offMinute} = {1'b1, 5'(off / 60), 6'(off % 60)};
    av(1'b1, 5'h10 + 5'(4 * c), w, r);
    // Stored word after clean-up: days and times always paired
    if (on >= 0 && f < 0) f = 0;
    if (off >= 0 && s < 0) s = 0;
    if (s >= 0 && f < 0) begin
      f = 0;
      on = 0;
    end
    if (f >= 0 && on < 0) on = 0;
    if (s >= 0 && off < 0) off = 0;
    fd[c] = f;
    sd[c] = s;
    onM[c] = on;
    offM[c] = off;
    recompute();
  endtask : wrch

  // Jump the clock; a changed minute value is a tick
  task automatic setTime(int d, int m);
    int old;
    old = curM % 60;
    @(posedge core_clk);
    load <= 1'b1;
    setDay <= 3'(d);
    setHour <= 5'(m / 60);
    setMinute <= 6'(m % 60);
    @(posedge core_clk);
    load <= 1'b0;
    curD = d;
    curM = m;
    if (old != m % 60) evalTick();
  endtask : setTime

  task automatic stepMin();
    @(posedge core_clk);
    step <= 1'b1;
    @(posedge core_clk);
    step <= 1'b0;
    curM++;
    if (curM == 1440) begin
      curM = 0;
      curD = (curD + 1) % 7;
    end
    evalTick();
  endtask : stepMin

  // Counts, verdict and end of run
  task automatic wrap_up();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge core_clk);
    chk(32'h0, 32'h1);
    wrap_up();
  end

  // Main sequence
  initial begin
    void'($urandom(98));
    for (int c = 0; c < 4; c++) {fd[c], sd[c], onM[c], offM[c]} = {-32'sd1, -32'sd1, -32'sd1, -32'sd1};
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    load <= 1'b0;
    repeat (6) @(posedge core_clk);
    av(1'b0, 5'h00, 32'h0, q); chk(q, 32'h0);
    av(1'b0, 5'h08, 32'h0, q); chk(q, 32'h0);
    av(1'b0, 5'h10, 32'h0, q); chk(q, 32'h0);
    chkOut();
    // Monday to Friday range on random weekdays, then the off edge
    wrch(0, 1, 5, 390, 540); chkOut();
    for (int i = 0; i < 8; i++) begin
      setTime($urandom % 7, 389); chkOut();
      stepMin(); chkOut();
    end
    setTime(1, 539); stepMin(); chkOut();
    // Fourth channel still on when the first off arrives
    wrch(3, 1, -1, 480, 600); chkOut();
    setTime(1, 539); stepMin(); chkOut();
    // Overnight span ends on the next day
    wrch(1, 3, -1, 1320, 360); setTime(3, 1319); stepMin(); chkOut();
    setTime(4, 359); chkOut();
    stepMin(); chkOut();
    // Equal times never switch on
    wrch(2, 6, -1, 720, 720); setTime(6, 719); stepMin(); chkOut();
    // Gating by the enable input
    setTime(1, 389); stepMin(); chkOut();
    av(1'b1, 5'h00, 32'h1, q);
    @(posedge core_clk);
    blockEnable <= 1'b0;
    run = 1'b0;
    evalTick(); chkOut();
    @(posedge core_clk);
    blockEnable <= 1'b1;
    run = 1'b1;
    recompute(); chkOut();
    av(1'b1, 5'h00, 32'h0, q);
    @(posedge core_clk);
    blockEnable <= 1'b0;
    chkOut();
    stepMin(); chkOut();
    blockEnable <= 1'b1;
    // Supply loss and return
    supplyGood <= 1'b0;
    run = 1'b0;
    evalTick();
    repeat (4) @(posedge core_clk); chkOut();
    stepMin(); chkOut();
    supplyGood <= 1'b1;
    run = 1'b1;
    recompute();
    repeat (4) @(posedge core_clk); chkOut();
    av(1'b0, 5'h04, 32'h0, q); chk({31'h0, q[0]}, {31'h0, expOut});
    // Edit lock, then write clean-up read back
    av(1'b1, 5'h00, 32'h4, q);
    av(1'b1, 5'h1C, 32'h0008_070A, q);
    av(1'b0, 5'h1C, 32'h0, q); chk(q, 32'h80A8_0889);
    av(1'b1, 5'h00, 32'h6, q);
    av(1'b1, 5'h1C, 32'h0008_070A, q);
    av(1'b0, 5'h1C, 32'h0, q); chk(q, 32'h0008_070A);
    av(1'b1, 5'h1C, 32'h0, q);
    av(1'b0, 5'h1C, 32'h0, q); chk(q, 32'h0);
    av(1'b1, 5'h1C, 32'h0009_E700, q);
    av(1'b0, 5'h1C, 32'h0, q); chk(q, 32'h0009_E708);
    av(1'b1, 5'h1C, 32'h0000_0009, q);
    av(1'b0, 5'h1C, 32'h0, q); chk(q, 32'h0008_0009);
    av(1'b1, 5'h1C, 32'h8120_00D0, q);
    av(1'b0, 5'h1C, 32'h0, q); chk(q, 32'h8128_00D8);
    av(1'b1, 5'h1C, 32'h000B_C609, q);
    av(1'b1, 5'h1C, 32'h0003_C600, q);
    av(1'b0, 5'h1C, 32'h0, q); chk(q, 32'h0);
    // Control write with lane 0 off leaves the control bits alone
    beMask = 4'hE;
    av(1'b1, 5'h00, 32'h0, q);
    beMask = 4'hF;
    av(1'b0, 5'h00, 32'h0, q); chk(q, 32'h6);
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire

// [tb/wts_rtc_model.sv]
// Calendar clock stand-in that feeds weekday, hour and minute to the switch
`timescale 1ns/10ps
`default_nettype none

module wts_rtc_model (
  input  wire logic       core_clk,   // Bench clock
  input  wire logic       load,       // Load a new time
  input  wire logic [2:0] setDay,     // Weekday to load
  input  wire logic [4:0] setHour,    // Hour to load
  input  wire logic [5:0] setMinute,  // Minute to load
  input  wire logic       step,       // Advance one minute
  output logic      [2:0] rtcWeekday, // Current weekday
  output logic      [4:0] rtcHour,    // Current hour
  output logic      [5:0] rtcMinute   // Current minute
);
  // Known time before the first edge
  initial begin
    rtcWeekday = 3'h0;
    rtcHour = 5'h00;
    rtcMinute = 6'h00;
  end

  // Counts on whatever the supply does; never leaves 00:00 to 23:59
  always @(posedge core_clk) begin
    if (load) begin
      rtcWeekday <= setDay;
      rtcHour <= setHour;
      rtcMinute <= setMinute;
    end else if (step) begin
      if (rtcMinute == 6'h3B) begin
        rtcMinute <= 6'h00;
        if (rtcHour == 5'h17) begin
          rtcHour <= 5'h00;
          rtcWeekday <= (rtcWeekday == 3'h6) ? 3'h0 : rtcWeekday + 3'h1;
        end else begin
          rtcHour <= rtcHour + 5'h01;
        end
      end else begin
        rtcMinute <= rtcMinute + 6'h01;
      end
    end
  end
endmodule : wts_rtc_model

`default_nettype wire
